// [shared/usb_init_pkg.sv]
// Purpose: shared constants for usb start-up, config loader and buffer addressing
// Assumes: 32-bit apb, one aligned word per register
// Notes:   config block byte layout is fixed here and used by loader and driver code
package usb_init_pkg;
    localparam int NUM_EP    = 5;
    localparam int CFG_BYTES = 5;
    localparam int ENDPOINT_NUMBER_FIELD_W   = 3;
    localparam int SIZE_W    = 10;
    localparam int PADDR_W   = 12;
    // register byte addresses
    localparam logic [11:0] ADDR_CTL   = 12'h000;
    localparam logic [11:0] ADDR_CLK   = 12'h004;
    localparam logic [11:0] ADDR_VAL   = 12'h008;
    localparam logic [11:0] ADDR_EPST0 = 12'h00c;
    localparam logic [11:0] ADDR_PAGE  = 12'h010;
    localparam logic [11:0] ADDR_OFS   = 12'h014;
    localparam logic [11:0] ADDR_CFGRD = 12'h018;
    localparam logic [11:0] ADDR_BASE0 = 12'h020;
    // field positions
    localparam int CTL_SRST   = 0;
    localparam int CTL_SPEED  = 1;
    localparam int CTL_INIT   = 2;
    localparam int CTL_ERR    = 3;
    localparam int CLK_PLL    = 0;
    localparam int CLK_UCEN   = 1;
    localparam int EPST_DONE  = 0;
    localparam int PAGE_DUAL  = 8;
    // reset values
    localparam logic RST_PLL   = 1'b0;
    localparam logic RST_SPEED = 1'b0;
    localparam logic RST_UCEN  = 1'b0;
    // soft reset duration in clock cycles
    localparam int SWRST_CYCLES = 8;
    // endpoint type and direction codes
    localparam logic [1:0] ENDPOINT_TYPE_FIELD_CTRL = 2'b00;
    localparam logic [1:0] ENDPOINT_TYPE_FIELD_ISO  = 2'b01;
    localparam logic [1:0] ENDPOINT_TYPE_FIELD_BULK = 2'b10;
    localparam logic [1:0] ENDPOINT_TYPE_FIELD_INT  = 2'b11;
    localparam logic DIR_OUT = 1'b0;
    localparam logic DIR_IN  = 1'b1;
    // config block: byte index of each field
    localparam logic [2:0] CB_EPNUM0  = 3'h0;
    localparam logic [2:0] CB_TYPEDIR = 3'h1;
    localparam logic [2:0] CB_SIZELO  = 3'h2;
    localparam logic [2:0] CB_EPNUM3  = 3'h3;
    localparam logic [2:0] CB_LAST    = 3'h4;
    localparam int CB_SIZEHI_LSB = 3;
    localparam int CB_DIR_BIT    = 2;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SWRST = 3'b010,
        ST_INIT  = 3'b100
    } ctl_state_t;
endpackage

// [test/testbench.sv]
// Purpose: directed bench for usb start-up, config loading and buffer addressing
// Assumes: one idle cycle between apb transfers is acceptable
// Notes:   base registers are only 8 bits, so addresses stay below 256
`timescale 1ns/1ps
module testbench;
    logic        clock, sys_rst, psel, penable, pwrite, pktStart, byteStrobe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pllEnable, usbClockEnable, fullSpeed, moduleReset;
    logic        initInProgress, memPage, er;
    logic [2:0]  accEp;
    logic [9:0]  memAddr;
    int          fails, samples_checked;
    usb_init_top dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pllEnable(pllEnable), .usbClockEnable(usbClockEnable),
        .fullSpeed(fullSpeed), .moduleReset(moduleReset), .initInProgress(initInProgress),
        .accEp(accEp), .pktStart(pktStart), .byteStrobe(byteStrobe), .memAddr(memAddr),
        .memPage(memPage));
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    task automatic final_report();
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // holds the request until pready; a lost answer ends the run
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20) begin
            fails++;
            final_report();
        end
    endtask
    task automatic bring_up();
        chk("reset ctl", 3'h0, {pllEnable, usbClockEnable, fullSpeed});
        apb(usb_init_pkg::ADDR_CTL, 1, 32'h3);
        repeat (3) @(posedge clock);
        chk("srst ignored", 2'h0, {moduleReset, fullSpeed});
        apb(usb_init_pkg::ADDR_CLK, 1, 32'h1);
        apb(usb_init_pkg::ADDR_CLK, 1, 32'h3);
        apb(usb_init_pkg::ADDR_CTL, 1, 32'h2);
        chk("speed locked", 1'h0, fullSpeed);
        chk("clk on", 2'h3, {pllEnable, usbClockEnable});
        apb(usb_init_pkg::ADDR_CTL, 1, 32'h3);
        for (int i = 0; i < 40 && initInProgress !== 1'b1; i++) @(posedge clock);
        if (initInProgress !== 1'b1) begin
            fails++;
            final_report();
        end
        apb(usb_init_pkg::ADDR_CTL, 0, 32'h0);
        chk("ctl after srst", 32'h6, rd);
        chk("full speed", 1'h1, fullSpeed);
        apb(12'h0fc, 0, 32'h0);
        chk("unmapped err", 32'h1, er);
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic load_config();
        logic [7:0] b [5];
        for (int e = 0; e < 5; e++) begin
            b = '{8'(e), 8'(((e == 0) ? 0 : e % 4) | (e % 2) << 2), 8'hff, 8'(e | 3 << 3), 8'h0};
            for (int k = 0; k < 5; k++) begin
                if (e == 4 && k == 4) chk("init held", 1'h1, initInProgress);
                apb(usb_init_pkg::ADDR_VAL, 1, {24'h0, b[k]});
            end
        end
        repeat (2) @(posedge clock);
        chk("init done", 1'h0, initInProgress);
        apb(usb_init_pkg::ADDR_EPST0, 1, 32'h1);
        apb(usb_init_pkg::ADDR_EPST0, 0, 32'h0);
        chk("ep0 done", 32'h1, rd);
        apb(usb_init_pkg::ADDR_CFGRD, 0, 32'h0);
        chk("ep0 block", 32'h0003ff00, rd);
        apb(usb_init_pkg::ADDR_CTL, 0, 32'h0);
        chk("no cfg error", 32'h2, rd);
    endtask
    task automatic pulse(input logic s, input logic p);
        @(posedge clock);
        pktStart <= s; byteStrobe <= p;
        @(posedge clock);
        pktStart <= 0; byteStrobe <= 0;
    endtask
    task automatic addressing();
        for (int n = 0; n < 5; n++) apb(12'h020 + 12'(4 * n), 1, 32'(8'h18 + 8'h20 * n));
        apb(usb_init_pkg::ADDR_PAGE, 1, 32'h5);
        accEp <= 3'h2;
        pulse(1, 0);
        @(posedge clock);
        chk("base ep2", 11'h058 | 11'h400, {memPage, memAddr});
        repeat (3) pulse(0, 1);
        @(posedge clock);
        chk("ep2 plus 3", 10'h05b, memAddr);
        apb(usb_init_pkg::ADDR_OFS, 0, 32'h0);
        chk("offset", 32'h3, rd);
        accEp <= 3'h1;
        pulse(1, 1);
        @(posedge clock);
        chk("restart ep1", 11'h038, {memPage, memAddr});
        accEp <= 3'h0;
        apb(usb_init_pkg::ADDR_PAGE, 1, 32'h105);
        pulse(1, 0);
        @(posedge clock);
        chk("dual ep0", 11'h018, {memPage, memAddr});
    endtask
    initial begin
        fails = 0; samples_checked = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; accEp = 3'h0; pktStart = 0; byteStrobe = 0;
        repeat (6) @(posedge clock);
        sys_rst <= 0;
        @(posedge clock);
        bring_up();
        load_config();
        addressing();
        final_report();
    end
endmodule // testbench

// [test/usb_init_props.sv]
// Purpose: port-level checks for the usb start-up and addressing block
// Assumes: apb master holds penable through the whole access phase
// Notes:   base registers are not visible here, so address checks are relative
`timescale 1ns/1ps
module usb_init_props #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    // control outputs
    input  wire logic              pllEnable,
    input  wire logic              usbClockEnable,
    input  wire logic              fullSpeed,
    input  wire logic              moduleReset,
    input  wire logic              initInProgress,
    // buffer access
    input  wire logic [2:0]        accEp,
    input  wire logic              pktStart,
    input  wire logic              byteStrobe,
    input  wire logic [ADDR_W-1:0] memAddr
);
    logic srstWrite;
    // an accepted soft reset request: clock running and no reset already under way
    assign srstWrite = psel && penable && pready && pwrite && usbClockEnable && !moduleReset
        && paddr == usb_init_pkg::ADDR_CTL && pwdata[usb_init_pkg::CTL_SRST];
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_rst_clear;
        disable iff (1'b0) sys_rst |=> !pllEnable && !usbClockEnable && !fullSpeed;
    endproperty
    property p_swr_cause;
        $rose(moduleReset) |-> $past(srstWrite);
    endproperty
    property p_swr_len;
        $rose(moduleReset) |-> moduleReset[*8] ##1 !moduleReset;
    endproperty
    property p_init_set;
        $fell(moduleReset) && !$past(sys_rst) |-> initInProgress;
    endproperty
    property p_init_cause;
        $rose(initInProgress) |-> $fell(moduleReset);
    endproperty
    property p_speed_lock;
        $changed(fullSpeed) |-> $past(srstWrite) || $past(sys_rst);
    endproperty
    property p_ready_wait;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    property p_err_pulse;
        pslverr |-> pready ##1 !pready;
    endproperty
    property p_offset_step;
        // a base write or a module reset one cycle back moves the base itself
        byteStrobe && !pktStart && !moduleReset && $stable(accEp)
            && !$past(moduleReset) && !$past(psel)
            |=> memAddr == $past(memAddr) + 1'b1;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("control bits not cleared");
    a_swr_cause: assert property (p_swr_cause) else $error("module reset without request");
    a_swr_len: assert property (p_swr_len) else $error("module reset length wrong");
    a_init_set: assert property (p_init_set) else $error("init flag not set");
    a_init_cause: assert property (p_init_cause) else $error("init flag rose early");
    a_speed_lock: assert property (p_speed_lock) else $error("speed bit changed");
    a_ready_wait: assert property (p_ready_wait) else $error("pready timing wrong");
    a_err_pulse: assert property (p_err_pulse) else $error("pslverr without pready");
    a_offset_step: assert property (p_offset_step) else $error("offset step wrong");
    c_swr: cover property ($fell(moduleReset));
    c_init: cover property ($fell(initInProgress));
    c_bytes: cover property (byteStrobe ##1 byteStrobe);
    c_err: cover property (pslverr);
endmodule // usb_init_props
bind usb_init_top usb_init_props #(.ADDR_W(ADDR_W)) props (.clock(clock), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .pllEnable(pllEnable),
    .usbClockEnable(usbClockEnable), .fullSpeed(fullSpeed), .moduleReset(moduleReset),
    .initInProgress(initInProgress), .accEp(accEp), .pktStart(pktStart),
    .byteStrobe(byteStrobe), .memAddr(memAddr));

// [verilog/usb_buf_addr.sv]
// Purpose: forms buffer memory address from endpoint base plus running byte offset
// Assumes: pktStart and byteStrobe are one-cycle pulses from the transfer logic
// Notes:   memAddr always shows the address of the next byte to be accessed
`timescale 1ns/1ps
module usb_buf_addr #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // configuration
    input  wire logic [5*8-1:0]    baseFlat,
    input  wire logic [5*3-1:0]    epNumFlat,
    input  wire logic [4:0]        pageSel,
    input  wire logic              dualBuf,
    // access side
    input  wire logic [2:0]        accEp,
    input  wire logic              pktStart,
    input  wire logic              byteStrobe,
    output logic [ADDR_W-1:0]      memAddr,
    output logic                   memPage,
    output logic [ADDR_W-1:0]      offset
);
    logic [4:0]        hit;
    logic [7:0]        base;
    logic              page;
    logic [ADDR_W-1:0] ofs_r, ofs_nxt, addr_r, addr_nxt;
    logic              page_r, page_nxt;

    for (genvar k = 0; k < 5; k++) begin : g_hit
        assign hit[k] = (epNumFlat[k*3 +: 3] == accEp);
    end

    always_comb begin
        base = 8'h00;
        page = 1'b0;
        for (int k = 0; k < 5; k++) begin
            if (hit[k]) begin
                base = baseFlat[k*8 +: 8];
                page = pageSel[k];
            end
        end
        ofs_nxt = ofs_r;
        if (pktStart) ofs_nxt = '0;
        else if (byteStrobe) ofs_nxt = ofs_r + 1'b1;
        addr_nxt = ADDR_W'(base) + ofs_nxt;
        // dual buffer mode holds memPage at 0, so the select bit is ignored
        page_nxt = dualBuf ? 1'b0 : page;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ofs_r  <= '0;
            addr_r <= '0;
            page_r <= 1'b0;
        end else begin
            ofs_r  <= ofs_nxt;
            addr_r <= addr_nxt;
            page_r <= page_nxt;
        end
    end

    assign memAddr = addr_r;
    assign memPage = page_r;
    assign offset  = ofs_r;
endmodule // usb_buf_addr

// [verilog/usb_cfg_loader.sv]
// Purpose: takes five config bytes per endpoint, endpoint 0 to 4, and stores fields
// Assumes: one byte per cycle at most, only while active
// Notes:   a field mismatch raises a sticky error but the sequence still advances
`timescale 1ns/1ps
module usb_cfg_loader (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // byte stream
    input  wire logic                active,
    input  wire logic                byteValid,
    input  wire logic [7:0]          byteData,
    // stored configuration
    output logic [5*3-1:0]           epNumFlat,
    output logic [5*2-1:0]           epTypeFlat,
    output logic [4:0]               epDirFlat,
    output logic [5*10-1:0]          epSizeFlat,
    output logic                     complete,
    output logic                     cfgError
);
    logic [2:0] byteIdx_r, byteIdx_nxt, epIdx_r, epIdx_nxt;
    logic [2:0] num_r [5];
    logic [2:0] num_nxt [5];
    logic [1:0] type_r [5];
    logic [1:0] type_nxt [5];
    logic [4:0] dir_r, dir_nxt;
    logic [9:0] size_r [5];
    logic [9:0] size_nxt [5];
    logic       done_r, done_nxt, err_r, err_nxt;
    logic       take;

    assign take = active && byteValid && !done_r;

    always_comb begin
        byteIdx_nxt = byteIdx_r;
        epIdx_nxt   = epIdx_r;
        num_nxt     = num_r;
        type_nxt    = type_r;
        dir_nxt     = dir_r;
        size_nxt    = size_r;
        done_nxt    = done_r;
        err_nxt     = err_r;
        if (take) begin
            unique case (byteIdx_r)
                usb_init_pkg::CB_EPNUM0: begin
                    num_nxt[epIdx_r] = byteData[2:0];
                    err_nxt = err_r || (byteData[2:0] != epIdx_r);
                end
                usb_init_pkg::CB_TYPEDIR: begin
                    type_nxt[epIdx_r] = byteData[1:0];
                    dir_nxt[epIdx_r]  = byteData[usb_init_pkg::CB_DIR_BIT];
                    // endpoint 0 must be a control endpoint
                    err_nxt = err_r || (epIdx_r == 3'h0 &&
                              byteData[1:0] != usb_init_pkg::ENDPOINT_TYPE_FIELD_CTRL);
                end
                usb_init_pkg::CB_SIZELO: size_nxt[epIdx_r][7:0] = byteData;
                usb_init_pkg::CB_EPNUM3: begin
                    size_nxt[epIdx_r][9:8] = byteData[4:3];
                    err_nxt = err_r || (byteData[2:0] != num_r[epIdx_r]);
                end
                default: ;
            endcase
            if (byteIdx_r == usb_init_pkg::CB_LAST) begin
                byteIdx_nxt = 3'h0;
                if (epIdx_r == 3'(usb_init_pkg::NUM_EP - 1)) done_nxt = 1'b1;
                else epIdx_nxt = epIdx_r + 3'h1;
            end else begin
                byteIdx_nxt = byteIdx_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            byteIdx_r <= 3'h0;
            epIdx_r   <= 3'h0;
            num_r     <= '{default: 3'h0};
            type_r    <= '{default: 2'h0};
            dir_r     <= 5'h00;
            size_r    <= '{default: 10'h000};
            done_r    <= 1'b0;
            err_r     <= 1'b0;
        end else begin
            byteIdx_r <= byteIdx_nxt;
            epIdx_r   <= epIdx_nxt;
            num_r     <= num_nxt;
            type_r    <= type_nxt;
            dir_r     <= dir_nxt;
            size_r    <= size_nxt;
            done_r    <= done_nxt;
            err_r     <= err_nxt;
        end
    end

    for (genvar k = 0; k < 5; k++) begin : g_flat
        assign epNumFlat[k*3 +: 3]   = num_r[k];
        assign epTypeFlat[k*2 +: 2]  = type_r[k];
        assign epSizeFlat[k*10 +: 10] = size_r[k];
    end
    assign epDirFlat = dir_r;
    assign complete  = done_r;
    assign cfgError  = err_r;
endmodule // usb_cfg_loader

// [verilog/usb_init_top.sv]
// Purpose: apb register front end, usb clock bring-up, soft reset and init sequencing
// Assumes: software follows the pll and clock bring-up order
// Notes:   pready follows one wait cycle after every setup phase
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - buffer address is endpoint base plus current byte offset.
// - stored endpoint number selects which base register is used.
// - single buffer uses page select bit; dual buffer ignores it.
// - hardware reset clears pll enable, full speed and usb clock enable.
// - setting soft reset bit resets the whole usb module; pll and usb clock enables keep their values here.
// - full speed bit changes only in the write setting soft reset.
// - soft reset end clears soft reset bit and sets init flag.
// - bytes arrive 0 to 4, endpoint 0 to 4, in order.
// - after all blocks are written the init flag clears.
// - endpoint number is three bits, in bytes 0 and 3.
// - type codes control, iso, bulk, interrupt; endpoint 0 is control.
// - direction 0 is host to cpu, 1 is cpu to host.
// - maximum packet size is ten bits, 0 to 1023.
module usb_init_top #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                sys_rst,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // control outputs
    output logic                     pllEnable,
    output logic                     usbClockEnable,
    output logic                     fullSpeed,
    output logic                     moduleReset,
    output logic                     initInProgress,
    // buffer access
    input  wire logic [2:0]          accEp,
    input  wire logic                pktStart,
    input  wire logic                byteStrobe,
    output logic [ADDR_W-1:0]        memAddr,
    output logic                     memPage
);
    // apb handshake
    logic        pready_r, pready_nxt, slverr_r, slverr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wrEn, rdSetup, decHit;
    logic [31:0] rdMux;

    // control registers
    logic        pll_r, pll_nxt, ucen_r, ucen_nxt, speed_r, speed_nxt;
    logic        srst_r, srst_nxt, init_r, init_nxt, ep0dn_r, ep0dn_nxt;
    logic [4:0]  page_r, page_nxt;
    logic        dual_r, dual_nxt;
    logic [7:0]  base_r [5];
    logic [7:0]  base_nxt [5];
    logic [5*8-1:0] baseFlat;
    logic [3:0]  rstCnt_r, rstCnt_nxt;
    usb_init_pkg::ctl_state_t state_r, state_nxt;
    logic        modRst_r, modRst_nxt;
    logic        innerRst;

    // loader and address generator
    logic        cfgByte, cfgDone, cfgErr;
    logic [14:0] epNumFlat;
    logic [9:0]  epTypeFlat;
    logic [4:0]  epDirFlat;
    logic [49:0] epSizeFlat;
    logic [ADDR_W-1:0] ofs;

    assign wrEn    = psel && penable && pready_r && pwrite;
    assign rdSetup = psel && !penable;
    assign innerRst = sys_rst || modRst_r;
    assign cfgByte = wrEn && paddr == usb_init_pkg::ADDR_VAL;

    // ---------------- apb read mux and decode ----------------
    always_comb begin
        rdMux  = 32'h0000_0000;
        decHit = 1'b1;
        unique case (paddr)
            usb_init_pkg::ADDR_CTL: begin
                // soft reset bit reads back while the reset is running
                rdMux[usb_init_pkg::CTL_SRST]  = srst_r;
                rdMux[usb_init_pkg::CTL_SPEED] = speed_r;
                rdMux[usb_init_pkg::CTL_INIT]  = init_r;
                rdMux[usb_init_pkg::CTL_ERR]   = cfgErr;
            end
            usb_init_pkg::ADDR_CLK: begin
                rdMux[usb_init_pkg::CLK_PLL]  = pll_r;
                rdMux[usb_init_pkg::CLK_UCEN] = ucen_r;
            end
            usb_init_pkg::ADDR_VAL:   rdMux = 32'h0000_0000;
            usb_init_pkg::ADDR_EPST0: rdMux[usb_init_pkg::EPST_DONE] = ep0dn_r;
            usb_init_pkg::ADDR_PAGE: begin
                rdMux[4:0] = page_r;
                rdMux[usb_init_pkg::PAGE_DUAL] = dual_r;
            end
            usb_init_pkg::ADDR_OFS:   rdMux[ADDR_W-1:0] = ofs;
            usb_init_pkg::ADDR_CFGRD: begin
                // endpoint 0 view of the stored block, for checking the load
                rdMux[2:0]   = epNumFlat[2:0];
                rdMux[5:4]   = epTypeFlat[1:0];
                rdMux[6]     = epDirFlat[0];
                rdMux[17:8]  = epSizeFlat[9:0];
            end
            default: begin
                decHit = 1'b0;
                for (int k = 0; k < 5; k++) begin
                    if (paddr == usb_init_pkg::ADDR_BASE0 + 12'(4 * k)) begin
                        rdMux[7:0] = base_r[k];
                        decHit = 1'b1;
                    end
                end
            end
        endcase
    end

    always_comb begin
        pready_nxt = psel && penable && !pready_r;
        rdata_nxt  = rdata_r;
        slverr_nxt = 1'b0;
        if (psel && penable && !pready_r) begin
            rdata_nxt  = pwrite ? 32'h0000_0000 : rdMux;
            slverr_nxt = !decHit;
        end
        if (rdSetup) rdata_nxt = 32'h0000_0000;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready_r <= 1'b0;
            slverr_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
        end else begin
            pready_r <= pready_nxt;
            slverr_r <= slverr_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ---------------- clock control (hardware reset only) ----------------
    always_comb begin
        pll_nxt  = pll_r;
        ucen_nxt = ucen_r;
        if (wrEn && paddr == usb_init_pkg::ADDR_CLK) begin
            pll_nxt  = pwdata[usb_init_pkg::CLK_PLL];
            ucen_nxt = pwdata[usb_init_pkg::CLK_UCEN];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pll_r  <= usb_init_pkg::RST_PLL;
            ucen_r <= usb_init_pkg::RST_UCEN;
        end else begin
            pll_r  <= pll_nxt;
            ucen_r <= ucen_nxt;
        end
    end

    // ---------------- soft reset and init sequencing ----------------
    always_comb begin
        state_nxt  = state_r;
        srst_nxt   = srst_r;
        speed_nxt  = speed_r;
        init_nxt   = init_r;
        rstCnt_nxt = rstCnt_r;
        modRst_nxt = 1'b0;
        unique case (state_r)
            usb_init_pkg::ST_IDLE, usb_init_pkg::ST_INIT: begin
                // a soft reset needs a running usb clock; otherwise it is ignored
                if (wrEn && paddr == usb_init_pkg::ADDR_CTL && ucen_r &&
                    pwdata[usb_init_pkg::CTL_SRST]) begin
                    srst_nxt   = 1'b1;
                    speed_nxt  = pwdata[usb_init_pkg::CTL_SPEED];
                    init_nxt   = 1'b0;
                    rstCnt_nxt = 4'(usb_init_pkg::SWRST_CYCLES - 1);
                    modRst_nxt = 1'b1;
                    state_nxt  = usb_init_pkg::ST_SWRST;
                end else if (state_r == usb_init_pkg::ST_INIT && cfgDone) begin
                    init_nxt  = 1'b0;
                    state_nxt = usb_init_pkg::ST_IDLE;
                end
            end
            usb_init_pkg::ST_SWRST: begin
                if (rstCnt_r == 4'h0) begin
                    srst_nxt  = 1'b0;
                    init_nxt  = 1'b1;
                    state_nxt = usb_init_pkg::ST_INIT;
                end else begin
                    rstCnt_nxt = rstCnt_r - 4'h1;
                    modRst_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = usb_init_pkg::ST_IDLE;
                srst_nxt  = 1'b0;
                init_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r  <= usb_init_pkg::ST_IDLE;
            srst_r   <= 1'b0;
            speed_r  <= usb_init_pkg::RST_SPEED;
            init_r   <= 1'b0;
            rstCnt_r <= 4'h0;
            modRst_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            srst_r   <= srst_nxt;
            speed_r  <= speed_nxt;
            init_r   <= init_nxt;
            rstCnt_r <= rstCnt_nxt;
            modRst_r <= modRst_nxt;
        end
    end

    // ---------------- module registers, cleared by soft reset too ----------------
    always_comb begin
        ep0dn_nxt = ep0dn_r;
        page_nxt  = page_r;
        dual_nxt  = dual_r;
        base_nxt  = base_r;
        if (wrEn && paddr == usb_init_pkg::ADDR_EPST0 &&
            pwdata[usb_init_pkg::EPST_DONE]) ep0dn_nxt = 1'b1;
        if (wrEn && paddr == usb_init_pkg::ADDR_PAGE) begin
            page_nxt = pwdata[4:0];
            dual_nxt = pwdata[usb_init_pkg::PAGE_DUAL];
        end
        for (int k = 0; k < 5; k++) begin
            if (wrEn && paddr == usb_init_pkg::ADDR_BASE0 + 12'(4 * k))
                base_nxt[k] = pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (innerRst) begin
            ep0dn_r <= 1'b0;
            page_r  <= 5'h00;
            dual_r  <= 1'b0;
            base_r  <= '{default: 8'h00};
        end else begin
            ep0dn_r <= ep0dn_nxt;
            page_r  <= page_nxt;
            dual_r  <= dual_nxt;
            base_r  <= base_nxt;
        end
    end

    for (genvar k = 0; k < 5; k++) begin : g_base
        assign baseFlat[k*8 +: 8] = base_r[k];
    end

    usb_cfg_loader u_loader (
        .clock      (clock),
        .rst        (innerRst),
        .active     (init_r),
        .byteValid  (cfgByte),
        .byteData   (pwdata[7:0]),
        .epNumFlat  (epNumFlat),
        .epTypeFlat (epTypeFlat),
        .epDirFlat  (epDirFlat),
        .epSizeFlat (epSizeFlat),
        .complete   (cfgDone),
        .cfgError   (cfgErr)
    );

    usb_buf_addr #(.ADDR_W(ADDR_W)) u_addr (
        .clock      (clock),
        .rst        (innerRst),
        .baseFlat   (baseFlat),
        .epNumFlat  (epNumFlat),
        .pageSel    (page_r),
        .dualBuf    (dual_r),
        .accEp      (accEp),
        .pktStart   (pktStart),
        .byteStrobe (byteStrobe),
        .memAddr    (memAddr),
        .memPage    (memPage),
        .offset     (ofs)
    );

    assign prdata         = rdata_r;
    assign pready         = pready_r;
    assign pslverr        = slverr_r;
    assign pllEnable      = pll_r;
    assign usbClockEnable = ucen_r;
    assign fullSpeed      = speed_r;
    assign moduleReset    = modRst_r;
    assign initInProgress = init_r;
endmodule // usb_init_top
